// File: logic/ptw2_pkg.sv
package ptw2_pkg;

  // Register byte addresses on the local register port
  localparam logic [31:0] BASE_REG_OFFSET     = 32'h0f000d18;
  localparam logic [31:0] IRQ_REG_OFFSET      = 32'h0f000d3c;

  // Base address register field positions
  localparam int          BASE_TOP_MSB        = 31;
  localparam int          BASE_TOP_LSB        = 28;
  localparam int          BASE_MASKED_MSB     = 27;
  localparam int          BASE_MASKED_LSB     = 21;
  localparam int          PREFETCH_BIT        = 3;
  localparam int          TYPE_MSB            = 2;
  localparam int          TYPE_LSB            = 1;
  localparam int          MEM_SPACE_BIT       = 0;

  // Base address register fixed and reset values
  localparam logic [3:0]  BASE_TOP_RESET      = 4'h0;
  localparam logic [6:0]  BASE_MASKED_RESET   = 7'h00;
  localparam logic [16:0] BASE_LOW_ZERO       = 17'h00000;
  localparam logic        PREFETCH_RESET      = 1'b1;
  localparam logic [1:0]  TYPE_ANY_32BIT      = 2'h0;
  localparam logic        MEM_SPACE_MEMORY    = 1'b0;

  // Interrupt register fields and values
  localparam int          IRQ_PIN_MSB         = 15;
  localparam int          IRQ_PIN_LSB         = 8;
  localparam int          IRQ_LINE_MSB        = 7;
  localparam int          IRQ_LINE_LSB        = 0;
  localparam logic [7:0]  IRQ_PIN_CODE        = 8'h01;
  localparam logic [7:0]  IRQ_LINE_RESET      = 8'h00;
  localparam logic [15:0] IRQ_RESERVED_ZERO   = 16'h0000;

  localparam logic [31:0] READ_IDLE_VALUE     = 32'h00000000;

endpackage : ptw2_pkg

// File: logic/ptw2_hit_decode.sv
`timescale 1ns/1ns
// Combinational window hit check for one incoming target address
module ptw2_hit_decode (
  input  wire logic [31:0] addr,        // Incoming target address
  input  wire logic [3:0]  base_top,    // Base bits always compared
  input  wire logic [6:0]  base_masked, // Base bits already ANDed with the mask
  input  wire logic [6:0]  size_mask,   // Window size mask, 1 marks a compared bit
  output logic             hit          // Address falls inside the window
);

  // Bits whose mask is zero lie inside the window and are ignored
  function automatic logic window_match(input logic [31:0] a, input logic [3:0] top,
                                        input logic [6:0] masked, input logic [6:0] m);
    window_match = (a[ptw2_pkg::BASE_TOP_MSB:ptw2_pkg::BASE_TOP_LSB] == top) &&
                   ((a[ptw2_pkg::BASE_MASKED_MSB:ptw2_pkg::BASE_MASKED_LSB] & m) == (masked & m));
  endfunction : window_match

  assign hit = window_match(addr, base_top, base_masked, size_mask);

endmodule : ptw2_hit_decode

// File: logic/ptw2_regs.sv
`timescale 1ns/1ns
module ptw2_regs (
  input  wire logic        CORE_CLK,       // 50 MHz register clock
  input  wire logic        SRST,           // System reset, synchronous, active high
  input  wire logic        RTC_RST,        // Clock-domain reset, synchronous, active high
  input  wire logic [31:0] REG_ADDR,       // Register byte address
  input  wire logic [31:0] REG_WDATA,      // Register write data
  input  wire logic        REG_WR,         // Write strobe, one cycle
  input  wire logic        REG_RD,         // Read strobe, one cycle
  output logic      [31:0] REG_RDATA,      // Read data, valid the cycle after REG_RD
  input  wire logic [6:0]  WIN_SIZE_MASK,  // Window size mask from the window config register
  input  wire logic        TGT_REQ,        // Target memory transaction offered, one cycle
  input  wire logic [31:0] TGT_ADDR,       // Target transaction address
  input  wire logic        TGT_WRITE,      // Target transaction is a write
  output logic             TGT_HIT,        // Offered address lies inside the window
  output logic             FWD_REQ,        // Accepted transaction for the internal bus, one cycle
  output logic      [31:0] FWD_ADDR,       // Forwarded address
  output logic             FWD_WRITE,      // Forwarded direction, 1 is write
  output logic      [31:0] WIN_BASE,       // Current base address register value
  output logic      [7:0]  IRQ_LINE_NOTE   // Interrupt line note for software use
);

  logic        any_reset;
  logic        base_sel;
  logic        irq_sel;
  logic [3:0]  base_top_reg;
  logic [6:0]  base_masked_reg;
  logic        prefetch_reg;
  logic [7:0]  irq_line_reg;
  logic [31:0] base_word;
  logic [31:0] irq_word;
  logic [31:0] rdata_next;
  logic [31:0] rdata_reg;
  logic        hit;
  logic        fwd_req_reg;
  logic [31:0] fwd_addr_reg;
  logic        fwd_write_reg;

  // Either reset source brings the bank back to its reset values
  assign any_reset = SRST | RTC_RST;

  // Address decode of the two words
  always_comb begin
    base_sel = 1'b0;
    irq_sel  = 1'b0;
    if (REG_ADDR == ptw2_pkg::BASE_REG_OFFSET) begin
      base_sel = 1'b1;
    end else if (REG_ADDR == ptw2_pkg::IRQ_REG_OFFSET) begin
      irq_sel = 1'b1;
    end
  end

  // Upper base bits are always stored as written
  always_ff @(posedge CORE_CLK) begin
    if (any_reset) begin
      base_top_reg <= ptw2_pkg::BASE_TOP_RESET;
    end else if (REG_WR && base_sel) begin
      base_top_reg <= REG_WDATA[ptw2_pkg::BASE_TOP_MSB:ptw2_pkg::BASE_TOP_LSB];
    end
  end

  // Masked base bits: a cleared mask bit forces zero, which is how the host
  // sizing read reports the window size; the mask is sampled at write time,
  // so changing it later does not alter an already stored base
  always_ff @(posedge CORE_CLK) begin
    if (any_reset) begin
      base_masked_reg <= ptw2_pkg::BASE_MASKED_RESET;
    end else if (REG_WR && base_sel) begin
      base_masked_reg <= REG_WDATA[ptw2_pkg::BASE_MASKED_MSB:ptw2_pkg::BASE_MASKED_LSB]
                         & WIN_SIZE_MASK;
    end
  end

  // Prefetch flag is read-only; it only takes its reset value
  always_ff @(posedge CORE_CLK) begin
    if (any_reset) begin
      prefetch_reg <= ptw2_pkg::PREFETCH_RESET;
    end
  end

  // Interrupt line note: storage only, steers nothing in hardware
  always_ff @(posedge CORE_CLK) begin
    if (any_reset) begin
      irq_line_reg <= ptw2_pkg::IRQ_LINE_RESET;
    end else if (REG_WR && irq_sel) begin
      irq_line_reg <= REG_WDATA[ptw2_pkg::IRQ_LINE_MSB:ptw2_pkg::IRQ_LINE_LSB];
    end
  end

  // Read views; fixed fields ignore whatever is written to them
  assign base_word = {base_top_reg,
                      base_masked_reg,
                      ptw2_pkg::BASE_LOW_ZERO,
                      prefetch_reg,
                      ptw2_pkg::TYPE_ANY_32BIT,
                      ptw2_pkg::MEM_SPACE_MEMORY};
  assign irq_word  = {ptw2_pkg::IRQ_RESERVED_ZERO,
                      ptw2_pkg::IRQ_PIN_CODE,
                      irq_line_reg};

  // Read mux; unmapped addresses return zero
  always_comb begin
    rdata_next = ptw2_pkg::READ_IDLE_VALUE;
    if (REG_RD && base_sel) begin
      rdata_next = base_word;
    end else if (REG_RD && irq_sel) begin
      rdata_next = irq_word;
    end
  end

  // Read data stands only in the cycle after the strobe, zero otherwise
  always_ff @(posedge CORE_CLK) begin
    if (any_reset) begin
      rdata_reg <= ptw2_pkg::READ_IDLE_VALUE;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Window hit check against the stored base and the live mask
  ptw2_hit_decode u_hit (
    .addr        (TGT_ADDR),
    .base_top    (base_top_reg),
    .base_masked (base_masked_reg),
    .size_mask   (WIN_SIZE_MASK),
    .hit         (hit)
  );

  // Accepted transactions are captured for the internal bus side
  always_ff @(posedge CORE_CLK) begin
    if (any_reset) begin
      fwd_req_reg <= 1'b0;
    end else begin
      fwd_req_reg <= TGT_REQ & hit;
    end
  end

  // Address and direction held until the next accepted transaction
  always_ff @(posedge CORE_CLK) begin
    if (any_reset) begin
      fwd_addr_reg  <= ptw2_pkg::READ_IDLE_VALUE;
      fwd_write_reg <= 1'b0;
    end else if (TGT_REQ && hit) begin
      fwd_addr_reg  <= TGT_ADDR;
      fwd_write_reg <= TGT_WRITE;
    end
  end

  // Outputs
  assign REG_RDATA     = rdata_reg;
  assign TGT_HIT       = TGT_REQ & hit; // Claim is combinational so the target can respond at once
  assign FWD_REQ       = fwd_req_reg;
  assign FWD_ADDR      = fwd_addr_reg;
  assign FWD_WRITE     = fwd_write_reg;
  assign WIN_BASE      = base_word;
  assign IRQ_LINE_NOTE = irq_line_reg;

endmodule : ptw2_regs

// File: testbench/ptw2_regs_properties.sv
`timescale 1ns/1ns
// Port-level checks of the window base and interrupt registers
module ptw2_regs_chk (
  input wire logic        CORE_CLK,      // Clock
  input wire logic        SRST,          // System reset
  input wire logic        RTC_RST,       // Clock-domain reset
  input wire logic [31:0] REG_ADDR,      // Address
  input wire logic [31:0] REG_WDATA,     // Write data
  input wire logic        REG_WR,        // Write strobe
  input wire logic        REG_RD,        // Read strobe
  input wire logic [31:0] REG_RDATA,     // Read data
  input wire logic [6:0]  WIN_SIZE_MASK, // Size mask
  input wire logic        TGT_REQ,       // Offer
  input wire logic [31:0] TGT_ADDR,      // Offer address
  input wire logic        TGT_HIT,       // Hit
  input wire logic        FWD_REQ,       // Forward pulse
  input wire logic [31:0] FWD_ADDR,      // Forward address
  input wire logic [31:0] WIN_BASE,      // Base word
  input wire logic [7:0]  IRQ_LINE_NOTE  // Line note
);
  localparam logic [31:0] BA = ptw2_pkg::BASE_REG_OFFSET;
  localparam logic [31:0] IA = ptw2_pkg::IRQ_REG_OFFSET;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SRST || RTC_RST);
  // Register accesses, each one cycle long
  sequence base_wr; REG_WR && REG_ADDR == BA; endsequence
  sequence irq_wr; REG_WR && REG_ADDR == IA; endsequence
  sequence irq_rd; REG_RD && REG_ADDR == IA; endsequence
  chk_low_zero: assert property (WIN_BASE[20:4] == 17'h00000)
    else $error("base low bits not zero");
  chk_base_hold: assert property (!(REG_WR && REG_ADDR == BA) |=> $stable(WIN_BASE))
    else $error("base changed without a write");
  chk_mask_store: assert property (base_wr |=> WIN_BASE[31:21] ==
    {$past(REG_WDATA[31:28]), $past(REG_WDATA[27:21]) & $past(WIN_SIZE_MASK)})
    else $error("base not stored through mask");
  chk_prefetchable_flag_type: assert property (WIN_BASE[3:1] == 3'h4)
    else $error("prefetch or type bits wrong");
  chk_mem_space: assert property (!WIN_BASE[0])
    else $error("space bit set");
  chk_irq_read: assert property (irq_rd |=> REG_RDATA[31:8] == 24'h000001)
    else $error("pin or reserved bits wrong");
  chk_line_note: assert property (irq_wr |=> IRQ_LINE_NOTE == $past(REG_WDATA[7:0]))
    else $error("line note not written");
  // The hit must follow the live mask on both sides
  chk_hit_match: assert property (TGT_HIT == (TGT_REQ && TGT_ADDR[31:28] == WIN_BASE[31:28] &&
    ((TGT_ADDR[27:21] ^ WIN_BASE[27:21]) & WIN_SIZE_MASK) == 7'h00))
    else $error("hit decode wrong");
  chk_fwd_pulse: assert property (TGT_HIT |=> FWD_REQ && FWD_ADDR == $past(TGT_ADDR))
    else $error("hit not forwarded");
  chk_no_fwd: assert property (!TGT_HIT |=> !FWD_REQ)
    else $error("forward without hit");
  chk_reset_vals: assert property (disable iff (1'b0) (SRST || RTC_RST) |=>
    WIN_BASE == 32'h00000008 && IRQ_LINE_NOTE == 8'h00)
    else $error("reset values wrong");
endmodule : ptw2_regs_chk
bind ptw2_regs ptw2_regs_chk u_chk (.CORE_CLK(CORE_CLK), .SRST(SRST), .RTC_RST(RTC_RST),
  .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .WIN_SIZE_MASK(WIN_SIZE_MASK), .TGT_REQ(TGT_REQ), .TGT_ADDR(TGT_ADDR), .TGT_HIT(TGT_HIT),
  .FWD_REQ(FWD_REQ), .FWD_ADDR(FWD_ADDR), .WIN_BASE(WIN_BASE), .IRQ_LINE_NOTE(IRQ_LINE_NOTE));

// File: testbench/ptw2_host_model.sv
`timescale 1ns/1ns
// Bus master offering memory transactions to the window
module ptw2_host_model (
  input  wire logic        clk,  // Clock
  input  wire logic        hit,  // Window hit answer
  output logic             req,  // Offer
  output logic      [31:0] addr, // Offer address
  output logic             wr    // Offer direction
);
  initial begin
    req = 1'b0;
    addr = 32'h00000000;
    wr = 1'b0;
  end
  // One-cycle offer; hit is combinational, so it is sampled inside the cycle
  task automatic offer(input logic [31:0] a, input logic w, output logic h);
    @(posedge clk);
    req <= 1'b1;
    addr <= a;
    wr <= w;
    #1 h = hit;
    @(posedge clk);
    req <= 1'b0;
    addr <= ~a; // Released lines show no stale value
    wr <= ~w;
  endtask : offer
endmodule : ptw2_host_model

// File: testbench/ptw2_regs_test.sv
`timescale 1ns/1ns
// Self-checking bench for the window base and interrupt registers
module ptw2_regs_test;
  localparam logic [31:0] BA = ptw2_pkg::BASE_REG_OFFSET;
  localparam logic [31:0] IA = ptw2_pkg::IRQ_REG_OFFSET;
  logic        clk = 1'b0, srst = 1'b1, rtc_rst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        t_req, t_wr, hit, f_req, f_wr, h;
  logic [6:0]  mask = 7'h7f;
  logic [7:0]  note;
  logic [31:0] addr = 32'h0, wdata = 32'h0, rdata, t_addr, f_addr, base, v;
  int          n_mismatch = 0, comparisons = 0, cycles = 0;
  always #10 clk = ~clk;
  ptw2_host_model m (.clk(clk), .hit(hit), .req(t_req), .addr(t_addr), .wr(t_wr));
  ptw2_regs dut (.CORE_CLK(clk), .SRST(srst), .RTC_RST(rtc_rst), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(rdata), .WIN_SIZE_MASK(mask), .TGT_REQ(t_req),
    .TGT_ADDR(t_addr), .TGT_WRITE(t_wr), .TGT_HIT(hit), .FWD_REQ(f_req), .FWD_ADDR(f_addr),
    .FWD_WRITE(f_wr), .WIN_BASE(base), .IRQ_LINE_NOTE(note));
  // Cuts a hung run short; the tests need well under 200 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_mismatch++;
      results();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = rdata;
  endtask : rd
  // Mask is set on a clock edge, before the host sizes the window
  task automatic t_sizing();
    @(posedge clk);
    mask <= 7'h0f;
    wr(BA, 32'hffffffff);
    rd(BA, v);
    check(v, 32'hf1e00008);
    check(base, 32'hf1e00008);
    rd(32'h0f000d1c, v);
    check(v, 32'h00000000);
    $display("sizing done");
  endtask : t_sizing
  // Reserved bits are written as zero; the pin byte write must be ignored
  task automatic t_irq();
    wr(IA, 32'h0000a55a);
    rd(IA, v);
    check(v, 32'h0000015a);
    check({24'h000000, note}, 32'h0000005a);
    $display("interrupt word done");
  endtask : t_irq
  // Hit, miss, then a miss turned into a hit by the live mask
  task automatic t_window();
    @(posedge clk);
    mask <= 7'h7f;
    wr(BA, 32'h30000000);
    m.offer(32'h301ffffc, 1'b1, h);
    #1 check({29'h0, h, f_req, f_wr}, 32'h00000007);
    check(f_addr, 32'h301ffffc);
    m.offer(32'h30200000, 1'b0, h);
    #1 check({29'h0, h, f_req, f_wr}, 32'h00000001);
    @(posedge clk);
    mask <= 7'h00;
    m.offer(32'h30200000, 1'b0, h);
    #1 check({29'h0, h, f_req, f_wr}, 32'h00000006);
    check(f_addr, 32'h30200000);
    $display("window done");
  endtask : t_window
  // System reset pulse first, so earlier tests leave nothing behind
  task automatic t_resets();
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    rd(BA, v);
    check(v, 32'h00000008);
    rd(IA, v);
    check(v, 32'h00000100);
    wr(IA, 32'h000000c3);
    @(posedge clk);
    rtc_rst <= 1'b1;
    @(posedge clk);
    rtc_rst <= 1'b0;
    rd(BA, v);
    check(v, 32'h00000008);
    check({24'h000000, note}, 32'h00000000);
    $display("resets done");
  endtask : t_resets
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    t_resets();
    t_sizing();
    t_irq();
    t_window();
    t_resets();
    results();
  end
endmodule : ptw2_regs_test
